// *** pwd_pkg.sv ***
// shared constants for the programmable wideband delay line
package pwd_pkg;
    // default build-time shape
    localparam int DEF_MAX_DELAY  = 1024;  // largest requested delay, sample clocks
    localparam int DEF_LANES_BITS = 2;     // log2 of simultaneous lanes
    localparam int DEF_DATA_W     = 8;     // bits per lane sample
    localparam int DEF_MEM_LAT    = 4;     // storage read latency, clocks
    localparam int MIN_MEM_LAT    = 1;     // smallest legal storage latency
    // storage flavour selection
    localparam bit MEM_SINGLE     = 1'b0;  // one shared address port
    localparam bit MEM_DUAL       = 1'b1;  // separate read and write ports
    // minimum-delay handling
    localparam bit MIN_ADDED      = 1'b1;  // minimum stacked on top of request
    // fixed offsets inside the pipeline
    localparam int STORE_OFS      = 1;     // storage holds request plus one
    localparam int FILL_STEP      = 1;     // fill counter increment
    localparam int PTR_STEP       = 1;     // write pointer increment
    // two-entry output buffer occupancy
    typedef enum logic [1:0] {
        PWD_BUF_EMPTY = 2'b00,
        PWD_BUF_ONE   = 2'b01,
        PWD_BUF_TWO   = 2'b10
    } pwd_buf_state_t;
endpackage : pwd_pkg

// *** pwd_mem.sv ***
// block memory with read-first access and a registered read pipeline
module pwd_mem #(
    parameter int W   = 9,
    parameter int AW  = 10,
    parameter int LAT = 4
) (
    // clock
    input  wire logic          clk_sys,
    // step enable, moves writes and the read pipeline
    input  wire logic          en,
    // write side
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read side, tied to wr_addr for single-port use
    input  wire logic [AW-1:0] rd_addr,
    output logic [W-1:0]       rd_data
);
    logic [W-1:0] store [2**AW];    // sample storage
    logic [W-1:0] pipe_reg  [LAT];  // read latency stages
    logic [W-1:0] pipe_next [LAT];  // next stage values

    // read-first: old word leaves before the new one lands
    always_comb begin
        pipe_next[0] = en ? store[rd_addr] : pipe_reg[0];
    end

    // remaining latency stages shift only on a step
    for (genvar i = 1; i < LAT; i++) begin : g_lat
        always_comb begin
            pipe_next[i] = en ? pipe_reg[i-1] : pipe_reg[i];
        end
    end

    // data path carries no reset; validity is tracked outside
    always_ff @(posedge clk_sys) begin
        pipe_reg <= pipe_next;
        if (en) begin
            store[wr_addr] <= wr_data;
        end
    end

    assign rd_data = pipe_reg[LAT-1];
endmodule : pwd_mem

// *** pwd_buf.sv ***
// two-entry output buffer with valid/ready on both sides
module pwd_buf #(
    parameter int W = 33
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // draining side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    pwd_pkg::pwd_buf_state_t st_reg, st_next;  // occupancy
    logic [W-1:0] head_reg, head_next;         // word offered downstream
    logic [W-1:0] tail_reg, tail_next;         // second word
    logic         rdy_reg, rdy_next;           // room for a push
    logic         vld_reg, vld_next;           // head holds a word
    logic         push;
    logic         pop;

    // occupancy and entry movement
    always_comb begin
        push      = in_valid && rdy_reg;
        pop       = vld_reg && out_ready;
        st_next   = st_reg;
        head_next = head_reg;
        tail_next = tail_reg;
        unique case (st_reg)
            pwd_pkg::PWD_BUF_EMPTY: begin
                if (push) begin
                    head_next = in_data;
                    st_next   = pwd_pkg::PWD_BUF_ONE;
                end
            end
            pwd_pkg::PWD_BUF_ONE: begin
                if (push && pop) begin
                    head_next = in_data;
                end else if (push) begin
                    tail_next = in_data;
                    st_next   = pwd_pkg::PWD_BUF_TWO;
                end else if (pop) begin
                    st_next   = pwd_pkg::PWD_BUF_EMPTY;
                end
            end
            pwd_pkg::PWD_BUF_TWO: begin
                // full: no push possible, ready is low
                if (pop) begin
                    head_next = tail_reg;
                    st_next   = pwd_pkg::PWD_BUF_ONE;
                end
            end
            default: begin
                st_next = pwd_pkg::PWD_BUF_EMPTY;
            end
        endcase
        rdy_next = (st_next != pwd_pkg::PWD_BUF_TWO);
        vld_next = (st_next != pwd_pkg::PWD_BUF_EMPTY);
    end

    // register everything; flags come out of flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg   <= pwd_pkg::PWD_BUF_EMPTY;
            head_reg <= '0;
            tail_reg <= '0;
            rdy_reg  <= 1'b1;
            vld_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            head_reg <= head_next;
            tail_reg <= tail_next;
            rdy_reg  <= rdy_next;
            vld_reg  <= vld_next;
        end
    end

    assign in_ready  = rdy_reg;
    assign out_valid = vld_reg;
    assign out_data  = head_reg;
endmodule : pwd_buf

// *** pwd_delay.sv ***
// run-time programmable delay line for a group of parallel sample lanes
//
// Operation
// - delay data by unsigned run-time delay input
// - build ceiling sets maximum delay and storage
// - power-of-two lane count from log2 parameter
// - build choice of single or dual port
// - storage read latency parameter enters pipeline
// - fixed minimum delay added by default
// - non power-of-two maximum rounds to power
// - sync in aligns block; sync out emitted
// - all lanes delayed together, type kept
// - single port may glitch on delay increase
// - storage latency at least 1, default 4
module pwd_delay #(
    parameter int MAX_DELAY  = pwd_pkg::DEF_MAX_DELAY,
    parameter int LANES_BITS = pwd_pkg::DEF_LANES_BITS,
    parameter int DATA_W     = pwd_pkg::DEF_DATA_W,
    parameter int MEM_LAT    = pwd_pkg::DEF_MEM_LAT,
    parameter bit MEM_TYPE   = pwd_pkg::MEM_DUAL,
    parameter bit ADD_MIN    = pwd_pkg::MIN_ADDED,
    // derived shape, not meant to be overridden
    parameter int LANES      = 2**LANES_BITS,
    parameter int DW         = $clog2(MAX_DELAY + 1),
    parameter int AW         = $clog2(MAX_DELAY + 1)
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // run-time delay request
    input  wire logic [DW-1:0]           delay,
    // upstream stream
    input  wire logic                    in_valid,
    input  wire logic                    sync_in,
    input  wire logic [LANES*DATA_W-1:0] data_in,
    output logic                         in_ready,
    // downstream stream
    output logic                         out_valid,
    output logic                         sync_out,
    output logic [LANES*DATA_W-1:0]      data_out,
    input  wire logic                    out_ready,
    // status
    output logic [DW:0]                  delay_total
);
    // storage depth rounded up to a power of two
    localparam int DEPTH    = 2**AW;
    localparam int SW       = AW + 1;                 // holds DEPTH itself
    localparam int WORD_W   = LANES * DATA_W + 1;     // lanes plus sync bit
    localparam int MIN_DLY  = MEM_LAT + pwd_pkg::STORE_OFS;

    // typed copies so widths match what they meet
    localparam logic [DW-1:0] MAX_D    = DW'(MAX_DELAY);
    localparam logic [DW:0]   MIN_D    = (DW + 1)'(MIN_DLY);
    localparam logic [SW-1:0] OFS_S    = SW'(pwd_pkg::STORE_OFS);
    localparam logic [SW-1:0] FILL_ONE = SW'(pwd_pkg::FILL_STEP);
    localparam logic [SW-1:0] DEPTH_S  = SW'(DEPTH);
    localparam logic [AW-1:0] PTR_ONE  = AW'(pwd_pkg::PTR_STEP);

    // latency below the legal floor cannot build a pipeline
    if (MEM_LAT < pwd_pkg::MIN_MEM_LAT) begin : g_bad_lat
        $error("storage latency must be at least one");
    end

    // clamp a request to what the storage can hold
    function automatic logic [DW-1:0] clamp_delay(input logic [DW-1:0] d);
        clamp_delay = (d > MAX_D) ? MAX_D : d;
    endfunction : clamp_delay

    // cycles spent inside the storage for a clamped request
    function automatic logic [SW-1:0] store_len(input logic [DW-1:0] d);
        logic [DW:0] wide;
        wide = {1'b0, d};
        if (ADD_MIN) begin
            store_len = SW'(d) + OFS_S;
        end else if (wide > MIN_D) begin
            store_len = SW'(wide - MIN_D) + OFS_S;            // request covers minimum
        end else begin
            store_len = OFS_S;                                // floor at the minimum
        end
    endfunction : store_len

    // ---------------------------------------------------------------
    // step control
    // ---------------------------------------------------------------
    logic              step;          // one accepted input sample
    logic              buf_ready;     // output buffer has room
    logic [DW-1:0]     d_clamped;     // request after clamping
    logic [SW-1:0]     s_len;         // storage residency in steps

    // the whole line moves only when input arrives and the buffer has room,
    // so a downstream stall backs up to the source instead of losing words
    always_comb begin
        step      = in_valid && buf_ready;
        d_clamped = clamp_delay(delay);
        s_len     = store_len(d_clamped);
    end

    // ---------------------------------------------------------------
    // write pointer, fill level and applied-delay status
    // ---------------------------------------------------------------
    logic [AW-1:0]     wptr_reg, wptr_next;   // storage write address
    logic [SW-1:0]     fill_reg, fill_next;   // words written, saturating
    logic [DW:0]       tot_reg,  tot_next;    // total applied delay
    logic [AW-1:0]     rd_addr;               // storage read address
    logic              rd_ok;                 // read word was written by us

    // pointer walk depends on the storage flavour
    always_comb begin
        wptr_next = wptr_reg;
        fill_next = fill_reg;
        if (step) begin
            if (MEM_TYPE == pwd_pkg::MEM_DUAL) begin
                wptr_next = wptr_reg + PTR_ONE;               // free-running ring
            end else if (SW'(wptr_reg) + FILL_ONE >= s_len) begin
                wptr_next = '0;                               // ring of length s_len
            end else begin
                wptr_next = wptr_reg + PTR_ONE;
            end
            if (fill_reg < DEPTH_S) begin
                fill_next = fill_reg + FILL_ONE;
            end
        end
        tot_next = SW'(s_len) + (DW + 1)'(MEM_LAT);
    end

    // read address: dual port looks back s_len words; single port reads
    // the slot it is about to overwrite, so a longer ring briefly replays
    // stale words after the delay grows
    always_comb begin
        if (MEM_TYPE == pwd_pkg::MEM_DUAL) begin
            rd_addr = wptr_reg - AW'(s_len);
        end else begin
            rd_addr = wptr_reg;
        end
        // suppress output until storage holds enough history
        rd_ok = (fill_reg >= s_len);
    end

    // pointer group registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            fill_reg <= '0;
            tot_reg  <= '0;
        end else begin
            wptr_reg <= wptr_next;
            fill_reg <= fill_next;
            tot_reg  <= tot_next;
        end
    end

    // ---------------------------------------------------------------
    // storage: sync bit travels in the same word as the lanes
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] wr_word;       // packed sync and lanes
    logic [WORD_W-1:0] rd_word;       // word after read latency

    // one word per step keeps every lane and the sync on the same clock
    always_comb begin
        wr_word = {sync_in, data_in};
    end

    pwd_mem #(
        .W       (WORD_W),
        .AW      (AW),
        .LAT     (MEM_LAT)
    ) u_mem (
        .clk_sys (clk_sys),
        .en      (step),
        .wr_addr (wptr_reg),
        .wr_data (wr_word),
        .rd_addr (rd_addr),
        .rd_data (rd_word)
    );

    // ---------------------------------------------------------------
    // validity pipeline matched to the storage read latency
    // ---------------------------------------------------------------
    logic [MEM_LAT-1:0] vpipe_reg, vpipe_next;  // word-valid per stage
    logic               push_valid;             // word ready for buffer

    // validity shifts only on a step, exactly like the storage pipe
    always_comb begin
        vpipe_next = vpipe_reg;
        if (step) begin
            vpipe_next[0] = rd_ok;
            for (int i = 1; i < MEM_LAT; i++) begin
                vpipe_next[i] = vpipe_reg[i-1];
            end
        end
        push_valid = step && vpipe_reg[MEM_LAT-1];
    end

    // validity registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vpipe_reg <= '0;
        end else begin
            vpipe_reg <= vpipe_next;
        end
    end

    // ---------------------------------------------------------------
    // two-entry output buffer; all stream outputs come from its flops
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] out_word;      // buffered sync and lanes

    pwd_buf #(
        .W         (WORD_W)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (push_valid),
        .in_data   (rd_word),
        .in_ready  (buf_ready),
        .out_valid (out_valid),
        .out_data  (out_word),
        .out_ready (out_ready)
    );

    // unpack: sync emitted on the same word as its delayed frame edge
    assign sync_out    = out_word[WORD_W-1];
    assign data_out    = out_word[WORD_W-2:0];
    assign in_ready    = buf_ready;
    assign delay_total = tot_reg;
endmodule : pwd_delay

// *** pwd_delay_properties.sv ***
// port-level checker for the programmable delay line
module pwd_delay_chk #(
    parameter int MAX_DELAY = 8,
    parameter int MEM_LAT   = 4,
    parameter int DW        = 4,
    parameter int LANES     = 4,
    parameter int DATA_W    = 8
) (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    // upstream side
    input wire logic [DW-1:0]           delay,
    input wire logic                    in_valid,
    input wire logic                    in_ready,
    // downstream side
    input wire logic                    out_valid,
    input wire logic                    out_ready,
    input wire logic                    sync_out,
    input wire logic [LANES*DATA_W-1:0] data_out,
    // status
    input wire logic [DW:0]             delay_total
);
    // accepted steps since reset, saturating so it never wraps
    logic [5:0] steps_reg;
    logic [5:0] steps_next;

    // next step count
    always_comb begin
        steps_next = steps_reg;
        if (!rst_n) begin
            steps_next = 6'h00;
        end else if (in_valid && in_ready && steps_reg != 6'h3f) begin
            steps_next = steps_reg + 6'h01;
        end
    end

    // register the count
    always_ff @(posedge clk_sys) begin
        steps_reg <= steps_next;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_reset_idle: assert property ($rose(rst_n) |-> !out_valid && in_ready && !sync_out
        && delay_total == '0) else $error("outputs not idle after reset");
    a_total_sum: assert property ($past(rst_n) |-> delay_total ==
        ((($past(delay) > MAX_DELAY) ? MAX_DELAY : $past(delay)) + 1 + MEM_LAT))
        else $error("total delay differs from request plus minimum");
    a_total_cap: assert property (delay_total <= MAX_DELAY + 1 + MEM_LAT)
        else $error("total delay above ceiling");
    // a word cannot surface before its full delay of steps has passed
    a_warm_quiet: assert property (out_valid |-> steps_reg > delay_total)
        else $error("word emerged too early");
    a_stall_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable(data_out) && $stable(sync_out)) else $error("output moved while stalled");
    a_full_valid: assert property (!in_ready |-> out_valid)
        else $error("input refused with nothing buffered");
    a_full_hold: assert property (!in_ready && !out_ready |=> !in_ready)
        else $error("full buffer freed without a pop");
    a_ready_pop: assert property (!in_ready && out_ready |=> in_ready)
        else $error("pop did not free a slot");
endmodule : pwd_delay_chk

bind pwd_delay pwd_delay_chk #(.MAX_DELAY(MAX_DELAY), .MEM_LAT(MEM_LAT), .DW(DW),
    .LANES(LANES), .DATA_W(DATA_W)) u_chk (.clk_sys, .rst_n, .delay, .in_valid, .in_ready,
    .out_valid, .out_ready, .sync_out, .data_out, .delay_total);

// *** pwd_sink.sv ***
// downstream partner: accepts promptly, at random or not at all
module pwd_sink (
    // clock
    input wire logic       clk_sys,
    // pace: 0 always ready, 1 random, 2 stalled
    input wire logic [1:0] pace,
    // acceptance toward the delay line
    output logic           out_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    initial out_ready = 1'b1;

    // ready moves off the sampling edge; a word is always taken whole
    always @(negedge clk_sys) begin
        case (pace)
            2'h0: out_ready = 1'b1;
            2'h1: out_ready = ($urandom % 2) != 0;
            default: out_ready = 1'b0;
        endcase
    end
endmodule : pwd_sink

// *** tb.sv ***
// self-checking bench for the programmable delay line
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MD = 8;  // small ceiling keeps runs short
    localparam int ML = 4;
    localparam int DW = $clog2(MD + 1);
    localparam int W  = 4 * pwd_pkg::DEF_DATA_W;
    // dut connections
    logic          clk_sys  = 1'b0;
    logic          rst_n    = 1'b0;
    logic [DW-1:0] delay    = '0;
    logic          in_valid = 1'b0;
    logic          sync_in  = 1'b0;
    logic [W-1:0]  data_in  = '0;
    logic          in_ready, out_valid, sync_out, out_ready;
    logic [W-1:0]  data_out;
    logic [DW:0]   delay_total;
    logic [1:0]    pace     = 2'h0;
    // single-port twin: same stream, must behave identically at fixed delay
    logic          sp_in_ready, sp_out_valid, sp_sync_out;
    logic [W-1:0]  sp_data_out;
    logic [DW:0]   sp_delay_total;
    // scoreboard: words taken, oldest first
    logic [W:0]    sent_q[$];
    int            n_fail = 0, cmp_count = 0, n_pop = 0, n_take = 0;
    bit            took = 1'b0;

    always #25 clk_sys = ~clk_sys;

    pwd_delay #(.MAX_DELAY(MD), .MEM_LAT(ML)) u_dut (.clk_sys, .rst_n, .delay, .in_valid,
        .sync_in, .data_in, .in_ready, .out_valid, .sync_out, .data_out, .out_ready,
        .delay_total);
    pwd_sink u_sink (.clk_sys, .pace, .out_ready);
    // single-port storage flavour, otherwise never built by any scenario
    pwd_delay #(.MAX_DELAY(MD), .MEM_LAT(ML), .MEM_TYPE(pwd_pkg::MEM_SINGLE)) u_dut_sp (
        .clk_sys, .rst_n, .delay, .in_valid, .sync_in, .data_in,
        .in_ready    (sp_in_ready),
        .out_valid   (sp_out_valid),
        .sync_out    (sp_sync_out),
        .data_out    (sp_data_out),
        .out_ready,
        .delay_total (sp_delay_total));

    task automatic check_word(input logic [W:0] exp, input logic [W:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value data_out expected %h seen %h", exp, got);
        end
    endtask : check_word

    task automatic check_num(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num

    // total steps: clamped request plus the fixed minimum
    function automatic int exp_total(input int d);
        return ((d > MD) ? MD : d) + 1 + ML;
    endfunction : exp_total

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // record taken words, compare popped ones in order
    always @(posedge clk_sys) begin
        if (rst_n && in_valid && in_ready) begin
            sent_q.push_back({sync_in, data_in});
            n_take++;
            took = 1'b1;
        end
        // with the delay held constant both flavours give the same stream
        if (rst_n) check_num("single port outputs", {in_ready, out_valid, sync_out, delay_total},
            {sp_in_ready, sp_out_valid, sp_sync_out, sp_delay_total});
        if (rst_n && out_valid && out_valid && out_ready && sp_data_out !== data_out)
            check_word({sync_out, data_out}, {sp_sync_out, sp_data_out});
        if (rst_n && out_valid && out_ready) begin
            n_pop++;
            if (sent_q.size() == 0) check_num("spare word", 32'h0, 32'h1);
            else check_word(sent_q.pop_front(), {sync_out, data_out});
        end
    end

    // one reset, one stream of n words, then a drain of all but the last t words
    task automatic run_case(input int d, input int n, input bit gaps, input logic [1:0] mode);
        int t;
        int guard;
        t = exp_total(d);
        @(negedge clk_sys);
        rst_n = 1'b0;
        delay = d[DW-1:0];
        pace = mode;
        in_valid = 1'b0;
        repeat (4) @(negedge clk_sys);
        check_num("reset outputs", 32'h1, {out_valid, sync_out, in_ready});
        sent_q.delete();
        n_pop = 0;
        n_take = 0;
        took = 1'b0;
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        check_num("delay_total", t, delay_total);
        guard = 0;
        // hold each word until taken, then draw the next
        while (n_take < n && guard < 5000) begin
            if (!in_valid || took) begin
                took = 1'b0;
                in_valid = gaps ? (($urandom % 4) != 0) : 1'b1;
                sync_in = ($urandom % 8) == 0;
                data_in = $urandom;
            end
            @(negedge clk_sys);
            guard++;
        end
        in_valid = 1'b0;
        if (guard >= 5000) begin
            n_fail++;
            complete_run();
        end
        if (mode == 2'h2) check_num("in_ready when full", 32'h0, in_ready);
        pace = 2'h0;
        guard = 0;
        while (n_pop < n - t && guard < 200) begin
            @(negedge clk_sys);
            guard++;
        end
        if (guard >= 200) begin
            n_fail++;
            complete_run();
        end
        repeat (2) @(negedge clk_sys);
        check_num("words out", n - t, n_pop);
        check_num("words held", t, sent_q.size());
    endtask : run_case

    // main sequence: corners first, then random delays
    initial begin
        int d;
        void'($urandom(98));
        run_case(0, 40, 1'b0, 2'h0);
        run_case(MD, 60, 1'b1, 2'h1);
        run_case(15, 60, 1'b1, 2'h1);
        run_case(3, 3 + 1 + ML + 2, 1'b0, 2'h2);
        repeat (6) begin
            d = $urandom % (MD + 1);
            run_case(d, 50, 1'b1, 2'h1);
        end
        complete_run();
    end
endmodule : tb
